// [hw/mtsr_top.sv]
`timescale 1ns/1ps
// How it works
// - Enable command stores mask, bits gate events.
// - Enable bits 6 and 7 read zero.
// - Enable query returns mask unchanged.
// - Test completion sets event bit 0.
// - Test failure sets event bit 1.
// - Low amplitude bit 2, high bit 3.
// - Align done bit 4, align fail bit 5.
// - Event query without enable query returns and clears register.
// - Event read value lies in 0 to 63.
// - Only enabled events feed the summary.
// - Any enabled event sets mask summary.
// - Enabled summary sets status byte bit 7.
// - Enabled bit 7 raises service request.
// - Disabled events still latch, no summary.
module mtsr_top
  import mtsr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire mtsr_cmd_type cmd,
  input wire mtsr_events_type events,
  input wire logic operation_summary_bit_mask_enable,
  input wire logic srq_bit7_enable,
  output logic [REG_W-1:0] read_data,
  output logic read_valid,
  output logic mask_summary,
  output logic operation_summary_bit,
  output logic service_request
);
  logic [REG_W-1:0] enable_r, enable_nxt;
  logic [EVT_W-1:0] event_r, event_nxt;
  logic [REG_W-1:0] read_data_r, read_data_nxt;
  logic read_valid_r, read_valid_nxt;
  logic summ_r, summ_nxt;
  logic operation_summary_bit_r, operation_summary_bit_nxt;
  logic srq_r, srq_nxt;
  logic [EVT_W-1:0] set_vec;

  // The mask summary is the OR of the enabled event bits.
  function automatic logic mtsr_any_enabled(
    input logic [EVT_W-1:0] ev,
    input logic [REG_W-1:0] en
  );
    mtsr_any_enabled = |(ev & en[EVT_W-1:0]);
  endfunction : mtsr_any_enabled

  // The event byte carries zeros above the six defined bits.
  function automatic logic [REG_W-1:0] mtsr_event_word(
    input logic [EVT_W-1:0] ev
  );
    mtsr_event_word = {{(REG_W-EVT_W){1'b0}}, ev};
  endfunction : mtsr_event_word

  // Event bits are collected in their documented positions.
  assign set_vec = events;

  always_comb
  begin
    enable_nxt = enable_r;
    event_nxt = event_r;
    read_data_nxt = read_data_r;
    read_valid_nxt = 1'b0;
    if (cmd.enable_write)
    begin
      enable_nxt = cmd.data & ENABLE_USED;
    end
    if (cmd.enable_query)
    begin
      read_data_nxt = enable_r;
      read_valid_nxt = 1'b1;
    end
    else if (cmd.event_query)
    begin
      read_data_nxt = mtsr_event_word(event_r);
      read_valid_nxt = 1'b1;
      event_nxt = '0;
    end
    // A new event in the clearing cycle survives the clear.
    event_nxt = event_nxt | set_vec;
    summ_nxt = mtsr_any_enabled(event_nxt, enable_nxt);
    operation_summary_bit_nxt = summ_nxt & operation_summary_bit_mask_enable;
    srq_nxt = operation_summary_bit_nxt & srq_bit7_enable;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      enable_r <= ENABLE_RESET;
      event_r <= EVENT_RESET;
      read_data_r <= READ_RESET;
      read_valid_r <= 1'b0;
      summ_r <= 1'b0;
      operation_summary_bit_r <= 1'b0;
      srq_r <= 1'b0;
    end
    else
    begin
      enable_r <= enable_nxt;
      event_r <= event_nxt;
      read_data_r <= read_data_nxt;
      read_valid_r <= read_valid_nxt;
      summ_r <= summ_nxt;
      operation_summary_bit_r <= operation_summary_bit_nxt;
      srq_r <= srq_nxt;
    end
  end

  assign read_data = read_data_r;
  assign read_valid = read_valid_r;
  assign mask_summary = summ_r;
  assign operation_summary_bit = operation_summary_bit_r;
  assign service_request = srq_r;

  sequence s_event_query;
    cmd.event_query && !cmd.enable_query;
  endsequence

  sequence s_both_queries;
    cmd.enable_query && cmd.event_query;
  endsequence

  sequence s_no_query;
    !cmd.enable_query && !cmd.event_query;
  endsequence

  sequence s_quiet_events;
    events == '0;
  endsequence

  sequence s_events_present;
    events != '0;
  endsequence

  AST_ENABLE_STORE: assert property (@(posedge clk) disable iff (!rst_n)
    cmd.enable_write |=> enable_r == ($past(cmd.data) & ENABLE_USED))
    else $error("Enable mask not stored.");

  AST_ENABLE_HIGH_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    enable_r[REG_W-1:EVT_W] == '0)
    else $error("Unused enable bits not zero.");

  AST_ENABLE_QUERY: assert property (@(posedge clk) disable iff (!rst_n)
    (cmd.enable_query && !cmd.enable_write) |=>
    read_valid && read_data == $past(enable_r) && enable_r == $past(enable_r))
    else $error("Enable query wrong.");

  AST_ENABLE_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
    !cmd.enable_write |=> $stable(enable_r))
    else $error("Enable mask changed without a write.");

  AST_EVENT_SET: assert property (@(posedge clk) disable iff (!rst_n)
    events.test_done |=> event_r[BIT_TEST_DONE])
    else $error("Test done not latched.");

  AST_FAIL_SET: assert property (@(posedge clk) disable iff (!rst_n)
    events.test_fail |=> event_r[BIT_TEST_FAIL])
    else $error("Test fail not latched.");

  AST_AMP_SET: assert property (@(posedge clk) disable iff (!rst_n)
    events.amp_low |=> event_r[BIT_AMP_LOW])
    else $error("Low amplitude event not latched.");

  AST_AMP_HIGH_SET: assert property (@(posedge clk) disable iff (!rst_n)
    events.amp_high |=> event_r[BIT_AMP_HIGH])
    else $error("High amplitude event not latched.");

  AST_ALIGN_SET: assert property (@(posedge clk) disable iff (!rst_n)
    events.align_fail |=> event_r[BIT_ALIGN_FAIL])
    else $error("Align fail not latched.");

  AST_ALIGN_DONE_SET: assert property (@(posedge clk) disable iff (!rst_n)
    events.align_done |=> event_r[BIT_ALIGN_DONE])
    else $error("Align done not latched.");

  AST_EVENT_READ_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    s_event_query ##0 s_quiet_events |=>
    read_valid && read_data == {2'b00, $past(event_r)} && event_r == '0)
    else $error("Event read did not return and clear.");

  AST_SET_WINS: assert property (@(posedge clk) disable iff (!rst_n)
    s_event_query ##0 s_events_present |=> event_r == $past(events))
    else $error("Event raised during a read was lost.");

  AST_BOTH_QUERIES: assert property (@(posedge clk) disable iff (!rst_n)
    s_both_queries ##0 s_quiet_events |=>
    read_valid && read_data == $past(enable_r) && event_r == $past(event_r))
    else $error("Joint query did not favour the enable register.");

  AST_READ_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
    s_no_query |=> !read_valid)
    else $error("Read valid without a query.");

  AST_READ_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    s_no_query |=> $stable(read_data))
    else $error("Read data changed without a query.");

  AST_EVENT_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
    read_valid && $past(cmd.event_query) && !$past(cmd.enable_query) |->
    read_data <= 8'h3f)
    else $error("Event read out of range.");

  AST_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
    !(cmd.event_query && !cmd.enable_query) |=>
    (event_r & $past(event_r)) == $past(event_r))
    else $error("Event bit lost without read.");

  AST_SUMMARY: assert property (@(posedge clk) disable iff (!rst_n)
    mask_summary == |(event_r & enable_r[EVT_W-1:0]))
    else $error("Summary mismatch.");

  AST_NO_SUMMARY: assert property (@(posedge clk) disable iff (!rst_n)
    (event_r & enable_r[EVT_W-1:0]) == '0 |-> !mask_summary)
    else $error("Summary raised by a disabled event.");

  AST_OPERATION_SUMMARY_BIT_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    operation_summary_bit == (mask_summary && $past(operation_summary_bit_mask_enable)))
    else $error("Status byte bit 7 does not follow the enabled summary.");

  AST_SRQ_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    service_request == (operation_summary_bit && $past(srq_bit7_enable)))
    else $error("Service request does not follow enabled bit 7.");

  AST_OPERATION_SUMMARY_BIT_SRQ: assert property (@(posedge clk) disable iff (!rst_n)
    service_request |-> operation_summary_bit && $past(srq_bit7_enable))
    else $error("Service request without enabled bit 7.");

  AST_RESET_CLEAR: assert property (@(posedge clk)
    !rst_n |=> enable_r == ENABLE_RESET && event_r == EVENT_RESET && !read_valid &&
    !mask_summary && !operation_summary_bit && !service_request)
    else $error("Reset did not clear the registers.");
endmodule : mtsr_top

// [pkg/mtsr_pkg.sv]
package mtsr_pkg;
  localparam int EVT_W = 6;
  localparam int REG_W = 8;
  localparam logic [REG_W-1:0] ENABLE_RESET = 8'h00;
  localparam logic [EVT_W-1:0] EVENT_RESET = 6'h00;
  localparam logic [REG_W-1:0] READ_RESET = 8'h00;
  localparam logic [REG_W-1:0] ENABLE_USED = 8'h3f;
  localparam int BIT_TEST_DONE = 0;
  localparam int BIT_TEST_FAIL = 1;
  localparam int BIT_AMP_LOW = 2;
  localparam int BIT_AMP_HIGH = 3;
  localparam int BIT_ALIGN_DONE = 4;
  localparam int BIT_ALIGN_FAIL = 5;
  localparam int STB_OPERATION_SUMMARY_BIT_BIT = 7;

  typedef struct packed {
    logic align_fail;
    logic align_done;
    logic amp_high;
    logic amp_low;
    logic test_fail;
    logic test_done;
  } mtsr_events_type;

  typedef struct packed {
    logic enable_write;
    logic enable_query;
    logic event_query;
    logic [REG_W-1:0] data;
  } mtsr_cmd_type;
endpackage : mtsr_pkg

// [tb/mtsr_host.sv]
`timescale 1ns/1ps
module mtsr_host
(
  input wire logic clk,
  input wire logic sre_cmd,
  output logic sre_r
);
  always_ff @(posedge clk)
  begin
    sre_r <= sre_cmd;
  end
endmodule : mtsr_host

// [tb/mtsr_top_tb_top.sv]
`timescale 1ns/1ps
module mtsr_top_tb_top
  import mtsr_pkg::*;
();
  logic clk, rst_n, oen, sre_cmd, sre, rv, ms, ob, srq;
  logic [7:0] rd;
  mtsr_cmd_type cmd;
  mtsr_events_type ev;
  int bad_count, checks_done;
  mtsr_top u_mtsr_top(.clk(clk), .rst_n(rst_n), .cmd(cmd), .events(ev),
    .operation_summary_bit_mask_enable(oen), .srq_bit7_enable(sre), .read_data(rd), .read_valid(rv),
    .mask_summary(ms), .operation_summary_bit(ob), .service_request(srq));
  mtsr_host u_mtsr_host(.clk(clk), .sre_cmd(sre_cmd), .sre_r(sre));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task cyc();
    @(posedge clk);
    #1;
  endtask : cyc
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task drive(input logic [2:0] f, input logic [7:0] v);
    cmd = '{f[2], f[1], f[0], v};
    cyc();
    cmd = '0;
  endtask : drive
  task wr(input logic [7:0] v);
    drive(3'b100, v);
    cyc();
  endtask : wr
  task q(input logic [2:0] f, input logic [7:0] v, input logic [7:0] e, input string n);
    drive(f, v);
    chk("read_valid", {7'h00, rv}, 8'h01);
    chk(n, rd, e);
    cyc();
    chk("read_valid end", {7'h00, rv}, 8'h00);
    chk("read_data hold", rd, e);
  endtask : q
  task print_verdict();
    if (bad_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  initial
  begin
    bad_count = 0;
    checks_done = 0;
    rst_n = 1'b0;
    cmd = '0;
    ev = '0;
    oen = 1'b1;
    sre_cmd = 1'b1;
    repeat (3) cyc();
    rst_n = 1'b1;
    q(3'b010, 8'h00, 8'h00, "enable");
    q(3'b001, 8'h00, 8'h00, "event");
    wr(8'hff);
    q(3'b010, 8'h00, 8'h3f, "enable");
    q(3'b010, 8'h00, 8'h3f, "enable again");
    q(3'b110, 8'h02, 8'h3f, "enable old");
    q(3'b010, 8'h00, 8'h02, "enable new");
    for (int i = 0; i < 6; i++)
    begin
      ev = mtsr_events_type'(6'h01 << i);
      cyc();
      ev = '0;
      cyc();
      chk("summary", {5'h00, ms, ob, srq}, (i == 1) ? 8'h07 : 8'h00);
      q(3'b001, 8'h00, 8'h01 << i, "event");
      q(3'b001, 8'h00, 8'h00, "cleared");
      chk("summary cleared", {5'h00, ms, ob, srq}, 8'h00);
    end
    ev = mtsr_events_type'(6'h01);
    drive(3'b001, 8'h00);
    ev = '0;
    chk("clear read", rd, 8'h00);
    cyc();
    q(3'b001, 8'h00, 8'h01, "set wins");
    oen = 1'b0;
    ev = mtsr_events_type'(6'h02);
    cyc();
    ev = '0;
    cyc();
    chk("gated", {5'h00, ms, ob, srq}, 8'h04);
    sre_cmd = 1'b0;
    cyc();
    oen = 1'b1;
    cyc();
    cyc();
    chk("srq gated", {5'h00, ms, ob, srq}, 8'h06);
    sre_cmd = 1'b1;
    cyc();
    cyc();
    chk("srq", {5'h00, ms, ob, srq}, 8'h07);
    wr(8'h05);
    chk("disabled", {5'h00, ms, ob, srq}, 8'h00);
    q(3'b011, 8'h00, 8'h05, "both queries");
    q(3'b001, 8'h00, 8'h02, "kept");
    ev = mtsr_events_type'(6'h01);
    cyc();
    ev = '0;
    cyc();
    chk("before reset", {5'h00, ms, ob, srq}, 8'h07);
    rst_n = 1'b0;
    repeat (3) cyc();
    rst_n = 1'b1;
    chk("after reset", {5'h00, ms, ob, srq}, 8'h00);
    q(3'b010, 8'h00, 8'h00, "enable after reset");
    q(3'b001, 8'h00, 8'h00, "event after reset");
    print_verdict();
  end
endmodule : mtsr_top_tb_top
